// *** rtl/ifd_pkg.sv ***
// Constants and types for the instruction format decoder
package ifd_pkg;
	localparam int WORD_W = 16;
	localparam int OPC_W = 20;
	localparam int IMM_W = 32;
	localparam int CYC_W = 8;
	// Opcode widths of the one- and two-word layouts
	localparam logic [4:0] OCW_P0 = 5'h10;
	localparam logic [4:0] OCW_P3 = 5'h0d;
	localparam logic [4:0] OCW_P4 = 5'h0c;
	localparam logic [4:0] OCW_P34 = 5'h09;
	localparam logic [4:0] OCW_P44 = 5'h08;
	localparam logic [4:0] OCW_P444 = 5'h04;
	localparam logic [4:0] OCW_ESC = 5'h10;
	localparam logic [4:0] OCW_EXP = 5'h04;
	// Execute-stage cycles of control instructions
	localparam logic [CYC_W-1:0] CYC_ONE = 8'h01;
	localparam logic [CYC_W-1:0] CYC_LPR = 8'h02;
	localparam logic [CYC_W-1:0] CYC_CMPB = 8'h02;
	localparam logic [CYC_W-1:0] CYC_RET = 8'h05;
	// Exception entry cycles, narrow dispatch table
	localparam logic [CYC_W-1:0] ENT_INT = 8'h0c;
	localparam logic [CYC_W-1:0] ENT_NMI = 8'h0b;
	localparam logic [CYC_W-1:0] ENT_TRAP = 8'h09;
	localparam logic [CYC_W-1:0] ENT_ALT = 8'h0c;
	localparam logic [CYC_W-1:0] ENT_WIDE_ADD = 8'h01;
	localparam logic [3:0] REG_LOW_FIRST = 4'hc;
	localparam logic [1:0] LEN_ZERO = 2'h0;

	typedef enum logic [3:0] {
		FMT_P0 = 4'h0, FMT_P3 = 4'h1, FMT_P4 = 4'h2,
		FMT_P34 = 4'h3, FMT_P44 = 4'h4, FMT_P444 = 4'h5,
		FMT_P4_20 = 4'h6, FMT_P44_16 = 4'h7, FMT_P0_24 = 4'h8,
		FMT_TWO_WORD_ESCAPE = 4'h9,
		FMT_THREE_WORD_ESCAPE_TWENTY = 4'ha,
		FMT_THREE_WORD_ESCAPE_TWENTYFOUR = 4'hb,
		FMT_WIDE_IMMEDIATE = 4'hc
	} ifd_fmt_e;

	typedef enum logic [3:0] {
		CT_NONE = 4'h0, CT_LOAD_PROCESSOR_REG = 4'h1,
		CT_STORE_PROCESSOR_REG = 4'h2, CT_JUMP = 4'h3,
		CT_COND_BRANCH = 4'h4, CT_CMP_BRANCH = 4'h5,
		CT_EXCEPTION_RETURN = 4'h6, CT_WAIT = 4'h7,
		CT_IRQ_ENABLE = 4'h8
	} ifd_ctrl_e;

	typedef enum logic [2:0] {
		EX_INT = 3'h0, EX_NMI = 3'h1, EX_IRQ_STACK_ERROR = 3'h2,
		EX_TRACE_TRAP = 3'h3, EX_DEBUG_TRAP = 3'h4,
		EX_BREAKPOINT_TRAP = 3'h5, EX_OTHER_TRAP = 3'h6
	} ifd_exc_e;

	typedef enum logic [1:0] {
		ST_FIRST = 2'b00, ST_SECOND = 2'b01, ST_THIRD = 2'b10
	} ifd_state_e;
endpackage

// *** rtl/ifd_decoder.sv ***
// Variable-length instruction format decoder with timing attachment
// Notes on behaviour
// RQ1: Accept one to three words, zero-three operands
// RQ2: Odd instruction address is flagged invalid
// RQ3: Operands are nibbles from bit 0 upward
// RQ4: Opcode fills bits down from bit 15
// RQ5: 16-bit displacement, 20-bit label use two words
// RQ6: Escaped 20/24-bit labels, 32-bit immediates use three
// RQ7: Escape word, then two-word layout follows
// RQ8: Escape plus expansion nibble gives 20-bit opcode
// RQ9: One-word opcode widths 16,13,12,9,8,4
// RQ10: 20-bit high nibble from word one; 24 uses 8
// RQ11: Fixed cycles and flush for control ops
// RQ12: Conditional branches flush only when taken
// RQ13: Latency sums in-flight, entry, fetch, extras
// RQ14: Entry cycles 12/13, 11/12, 9/10 by table
// RQ15: Alternate handling bits force 12 cycles
// RQ16: Register codes 12-15 pick low halves
// RQ17: Length reported on the first word
// RQ18: Fetch supplies words in order, holds decode
module ifd_decoder
	import ifd_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Word stream from fetch
	input wire logic word_valid_i,
	input wire logic [ifd_pkg::WORD_W-1:0] word_i,
	input wire logic addr_lsb_i,
	input wire ifd_pkg::ifd_fmt_e fmt_i,
	input wire ifd_pkg::ifd_ctrl_e ctrl_i,
	output logic word_ready_o,
	output logic [1:0] len_o,
	// Execute-stage condition inputs
	input wire logic cond_true_i,
	input wire logic wait_irq_i,
	// Decoded instruction
	output logic dec_valid_o,
	output logic bad_addr_o,
	output logic [ifd_pkg::OPC_W-1:0] opcode_o,
	output logic [4:0] opcode_width_o,
	output logic [15:0] operands_o,
	output logic [ifd_pkg::IMM_W-1:0] imm_o,
	output logic [1:0] words_o,
	output logic [3:0] op1_reg_o,
	output logic op1_low_half_o,
	output logic [ifd_pkg::CYC_W-1:0] ex_cycles_o,
	output logic flush_o,
	// Exception timing
	input wire ifd_pkg::ifd_exc_e exc_i,
	input wire logic wide_dispatch_select_i,
	input wire logic alt_stack_error_handling_i,
	input wire logic alt_trace_handling_i,
	input wire logic alt_debug_handling_i,
	input wire logic alt_breakpoint_handling_i,
	input wire logic [ifd_pkg::CYC_W-1:0] inflight_cycles_i,
	input wire logic [ifd_pkg::CYC_W-1:0] fetch_cycles_i,
	input wire logic [ifd_pkg::CYC_W-1:0] extra_cycles_i,
	output logic [ifd_pkg::CYC_W-1:0] entry_cycles_o,
	output logic [ifd_pkg::CYC_W-1:0] latency_o
);
	import ifd_pkg::*;

	ifd_state_e state, next_state;
	ifd_fmt_e fmt_q;
	ifd_ctrl_e ctrl_q;
	logic [WORD_W-1:0] w1, w2;

	// Length known from the format on the first word
	logic [1:0] first_len;
	always_comb begin
		case (fmt_i)
			FMT_P0, FMT_P3, FMT_P4, FMT_P34, FMT_P44,
			FMT_P444: first_len = 2'h1; // RQ1
			FMT_P4_20, FMT_P44_16, FMT_P0_24,
			FMT_TWO_WORD_ESCAPE: first_len = 2'h2; // RQ5
			FMT_THREE_WORD_ESCAPE_TWENTY,
			FMT_THREE_WORD_ESCAPE_TWENTYFOUR,
			FMT_WIDE_IMMEDIATE: first_len = 2'h3; // RQ6
			default: first_len = 2'h1;
		endcase
	end

	wire take = word_valid_i;
	wire in_first = state == ST_FIRST;
	wire bad_first = take && in_first && addr_lsb_i; // RQ2
	wire ifd_fmt_e fmt_cur = in_first ? fmt_i : fmt_q;
	wire [1:0] len_cur = in_first ? first_len :
		(fmt_q inside {FMT_THREE_WORD_ESCAPE_TWENTY,
		FMT_THREE_WORD_ESCAPE_TWENTYFOUR,
		FMT_WIDE_IMMEDIATE}) ? 2'h3 : 2'h2;
	wire [1:0] pos = state == ST_FIRST ? 2'h1 :
		state == ST_SECOND ? 2'h2 : 2'h3;
	wire last = take && !bad_first && pos == len_cur;
	assign word_ready_o = 1'b1;
	assign len_o = (in_first && !word_valid_i) ? LEN_ZERO
		: len_cur; // RQ17

	always_comb begin
		next_state = state;
		case (state)
			ST_FIRST:
				if (take && !bad_first && !last)
					next_state = ST_SECOND; // RQ18
			ST_SECOND:
				if (take)
					next_state = last ? ST_FIRST : ST_THIRD;
			ST_THIRD:
				if (take)
					next_state = ST_FIRST;
			default: next_state = ST_FIRST;
		endcase
	end

	// Words as they stand when the last one arrives
	wire [15:0] a = in_first ? word_i : w1;
	wire [15:0] b = state == ST_SECOND ? word_i : w2;
	wire [15:0] c = word_i;
	wire esc = fmt_cur inside {FMT_TWO_WORD_ESCAPE,
		FMT_THREE_WORD_ESCAPE_TWENTY,
		FMT_THREE_WORD_ESCAPE_TWENTYFOUR};

	// Opcode width per format
	logic [4:0] ocw;
	always_comb begin
		case (fmt_cur)
			FMT_P0: ocw = OCW_P0; // RQ9
			FMT_P3: ocw = OCW_P3;
			FMT_P4, FMT_WIDE_IMMEDIATE: ocw = OCW_P4;
			FMT_P34: ocw = OCW_P34;
			FMT_P44, FMT_P4_20, FMT_P44_16,
			FMT_P0_24: ocw = OCW_P44; // RQ10
			FMT_P444: ocw = OCW_P444;
			default: ocw = OCW_ESC + OCW_EXP; // RQ8
		endcase
	end

	// The operand word is the one after the escape
	wire [15:0] opw = esc ? b : a; // RQ7
	wire [4:0] sh = esc ? 5'h0 : 5'h10 - ocw;
	wire [15:0] opc_plain = opw >> sh; // RQ4
	wire [19:0] opc = esc ? {a, b[15:12]} // RQ8
		: {4'h0, opc_plain};
	wire [15:0] opnd = esc ? {4'h0, b[11:0]}
		: (ocw == OCW_P0) ? 16'h0
		: opw & ~(16'hffff << sh); // RQ3

	// Displacement, label or immediate assembly
	logic [31:0] imm;
	always_comb begin
		case (fmt_cur)
			FMT_P4_20: imm = {12'h0, a[3:0], b}; // RQ10
			FMT_P44_16: imm = {16'h0, b}; // RQ5
			FMT_P0_24: imm = {8'h0, a[7:0], b}; // RQ10
			FMT_THREE_WORD_ESCAPE_TWENTY:
				imm = {12'h0, b[11:8], c}; // RQ6
			FMT_THREE_WORD_ESCAPE_TWENTYFOUR:
				imm = {8'h0, b[3:0], b[11:8], c};
			FMT_WIDE_IMMEDIATE: imm = {c, b}; // RQ6
			default: imm = 32'h0;
		endcase
	end

	// Control-instruction execute cycles and flush
	ifd_ctrl_e ctrl_cur;
	logic [CYC_W-1:0] cyc;
	logic fl;
	assign ctrl_cur = in_first ? ctrl_i : ctrl_q;
	always_comb begin
		cyc = CYC_ONE;
		fl = 1'b0;
		case (ctrl_cur)
			CT_LOAD_PROCESSOR_REG: begin
				cyc = CYC_LPR; // RQ11
				fl = 1'b1;
			end
			CT_JUMP: fl = 1'b1; // RQ11
			CT_COND_BRANCH: fl = cond_true_i; // RQ12
			CT_CMP_BRANCH: begin
				cyc = CYC_CMPB; // RQ12
				fl = cond_true_i;
			end
			CT_EXCEPTION_RETURN: begin
				cyc = CYC_RET; // RQ11
				fl = 1'b1;
			end
			CT_WAIT: fl = wait_irq_i; // RQ12
			default: fl = 1'b0;
		endcase
	end

	// Exception entry cost
	logic [CYC_W-1:0] ent_base;
	always_comb begin
		case (exc_i)
			EX_INT: ent_base = ENT_INT; // RQ14
			EX_NMI, EX_IRQ_STACK_ERROR: ent_base = ENT_NMI;
			default: ent_base = ENT_TRAP;
		endcase
	end
	wire alt_hit = (exc_i == EX_IRQ_STACK_ERROR &&
		alt_stack_error_handling_i) ||
		(exc_i == EX_TRACE_TRAP && alt_trace_handling_i) ||
		(exc_i == EX_DEBUG_TRAP && alt_debug_handling_i) ||
		(exc_i == EX_BREAKPOINT_TRAP &&
		alt_breakpoint_handling_i);
	wire [CYC_W-1:0] ent = alt_hit ? ENT_ALT // RQ15
		: ent_base + (wide_dispatch_select_i ?
		ENT_WIDE_ADD : 8'h0); // RQ14
	// Saturation is not applied: the sum is cut to CYC_W bits and wraps
	wire [CYC_W-1:0] lat = CYC_W'(inflight_cycles_i + ent +
		fetch_cycles_i + extra_cycles_i); // RQ13

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_FIRST;
			fmt_q <= FMT_P0;
			ctrl_q <= CT_NONE;
			w1 <= 16'h0;
			w2 <= 16'h0;
		end else begin
			state <= next_state;
			if (take && in_first) begin
				fmt_q <= fmt_i;
				ctrl_q <= ctrl_i;
				w1 <= word_i;
			end
			if (take && state == ST_SECOND)
				w2 <= word_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dec_valid_o <= 1'b0;
			bad_addr_o <= 1'b0;
			opcode_o <= 20'h0;
			opcode_width_o <= 5'h0;
			operands_o <= 16'h0;
			imm_o <= 32'h0;
			words_o <= 2'h0;
			op1_reg_o <= 4'h0;
			op1_low_half_o <= 1'b0;
			ex_cycles_o <= 8'h0;
			flush_o <= 1'b0;
		end else begin
			dec_valid_o <= last;
			bad_addr_o <= bad_first;
			flush_o <= last && fl;
			if (last) begin
				opcode_o <= opc;
				opcode_width_o <= ocw;
				operands_o <= opnd;
				imm_o <= imm;
				words_o <= len_cur;
				op1_reg_o <= opnd[3:0];
				// Codes 12-15 name low halves of wide regs
				op1_low_half_o <=
					opnd[3:0] >= REG_LOW_FIRST; // RQ16
				ex_cycles_o <= cyc;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			entry_cycles_o <= 8'h0;
			latency_o <= 8'h0;
		end else begin
			entry_cycles_o <= ent;
			latency_o <= lat;
		end
	end

	sequence s_three_words;
		word_valid_i && in_first && !addr_lsb_i &&
		first_len == 2'h3 ##1 word_valid_i [*2];
	endsequence

	AST_ODD_ADDR: assert property (@(posedge clock_i) // RQ2
		disable iff (!rst_n_i)
		bad_first |=> bad_addr_o && !dec_valid_o &&
		state == ST_FIRST)
		else $error("odd address not rejected");
	AST_ONE_WORD: assert property (@(posedge clock_i) // RQ1
		disable iff (!rst_n_i)
		word_valid_i && in_first && !addr_lsb_i &&
		first_len == 2'h1 |=> dec_valid_o && words_o == 2'h1)
		else $error("one-word decode missing");
	AST_THREE_WORD: assert property (@(posedge clock_i) // RQ6
		disable iff (!rst_n_i)
		s_three_words |=> dec_valid_o && words_o == 2'h3)
		else $error("three-word decode missing");
	AST_LEN_EARLY: assert property (@(posedge clock_i) // RQ17
		disable iff (!rst_n_i)
		word_valid_i && in_first |-> len_o ==
		(fmt_i inside {FMT_THREE_WORD_ESCAPE_TWENTY,
		FMT_THREE_WORD_ESCAPE_TWENTYFOUR, FMT_WIDE_IMMEDIATE} ? 2'h3 :
		fmt_i inside {FMT_P4_20, FMT_P44_16, FMT_P0_24,
		FMT_TWO_WORD_ESCAPE} ? 2'h2 : 2'h1))
		else $error("length not given on first word");
	AST_ESC_OPC: assert property (@(posedge clock_i) // RQ8
		disable iff (!rst_n_i)
		word_valid_i && in_first && !addr_lsb_i &&
		fmt_i == FMT_TWO_WORD_ESCAPE ##1 word_valid_i
		|=> opcode_o == {$past(word_i, 2),
		$past(word_i[15:12])})
		else $error("escape opcode wrong");
	AST_LPR: assert property (@(posedge clock_i) // RQ11
		disable iff (!rst_n_i)
		last && ctrl_cur == CT_LOAD_PROCESSOR_REG
		|=> ex_cycles_o == 8'h02 && flush_o)
		else $error("load processor reg timing wrong");
	AST_BRANCH: assert property (@(posedge clock_i) // RQ12
		disable iff (!rst_n_i)
		last && ctrl_cur == CT_COND_BRANCH
		|=> flush_o == $past(cond_true_i))
		else $error("branch flush wrong");
	AST_ENTRY: assert property (@(posedge clock_i) // RQ14
		disable iff (!rst_n_i)
		exc_i == EX_INT |=> entry_cycles_o ==
		($past(wide_dispatch_select_i) ? 8'h0d : 8'h0c))
		else $error("interrupt entry cycles wrong");
	AST_ALT: assert property (@(posedge clock_i) // RQ15
		disable iff (!rst_n_i)
		exc_i == EX_TRACE_TRAP && alt_trace_handling_i
		|=> entry_cycles_o == 8'h0c)
		else $error("alternate entry not 12");
	AST_LAT: assert property (@(posedge clock_i) // RQ13
		disable iff (!rst_n_i)
		1'b1 |=> latency_o == CYC_W'(entry_cycles_o +
		$past(inflight_cycles_i) + $past(fetch_cycles_i) +
		$past(extra_cycles_i)))
		else $error("latency sum wrong");
endmodule

// *** sim/ifd_fetch_model.sv ***
// Fetch and execute-stage model that feeds the decoder
module ifd_fetch_model
	import ifd_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// Word stream
	output logic word_valid_o,
	output logic [ifd_pkg::WORD_W-1:0] word_o,
	output logic addr_lsb_o,
	output ifd_pkg::ifd_fmt_e fmt_o,
	output ifd_pkg::ifd_ctrl_e ctrl_o,
	output logic first_o,
	// Execute-stage conditions
	output logic cond_true_o,
	output logic wait_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		word_valid_o = 1'b0;
		word_o = 16'h0000;
		addr_lsb_o = 1'b0;
		fmt_o = FMT_P0;
		ctrl_o = CT_NONE;
		first_o = 1'b0;
		cond_true_o = 1'b0;
		wait_irq_o = 1'b0;
	end

	// Idle word lines toggle so a stale word is never mistaken for data
	task automatic idle();
		word_valid_o = 1'b0;
		word_o = ~word_o;
		first_o = 1'b0;
	endtask

	// Words go out in address order; a gap stalls decode mid-instruction
	task automatic send(input logic [15:0] w [3], input int n,
		input ifd_fmt_e f, input ifd_ctrl_e c, input logic lsb,
		input logic cnd, input logic wirq, input int gap);
		for (int k = 0; k < n; k++) begin
			@(negedge clock_i);
			word_valid_o = 1'b1;
			word_o = w[k];
			first_o = (k == 0);
			addr_lsb_o = lsb;
			fmt_o = f;
			ctrl_o = c;
			cond_true_o = cnd;
			wait_irq_o = wirq;
			if (gap != 0 && k < n - 1) begin
				@(negedge clock_i);
				idle();
			end
		end
	endtask
endmodule

// *** sim/instruction_format_decoder_tb.sv ***
// Self-checking bench for the instruction format decoder
`define CHK(a, b, m) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("MISMATCH %0t %s", $time, m); \
	end \
end
module instruction_format_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ifd_pkg::*;

	typedef struct {
		logic bad;
		logic [1:0] words;
		logic [19:0] opc;
		logic [4:0] ow;
		logic [15:0] opr;
		logic [31:0] imm;
		logic [7:0] cyc;
		logic fl;
		logic [3:0] r1;
		bit k_opc;
		bit k_imm;
		bit k_r1;
	} ifd_note_s;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic word_valid, addr_lsb, first_word, cond_true, wait_irq;
	logic [15:0] word;
	ifd_fmt_e fmt;
	ifd_ctrl_e ctrl;
	logic word_ready, dec_valid, bad_addr, op1_low, flush;
	logic [1:0] len, words;
	logic [19:0] opcode;
	logic [4:0] owidth;
	logic [15:0] operands;
	logic [31:0] imm;
	logic [3:0] op1_reg;
	logic [7:0] ex_cycles, entry, latency, ent;
	ifd_exc_e exc = EX_INT;
	logic wide = 1'b0;
	logic [3:0] alt = 4'h0;
	logic [7:0] inflight = 8'h00, fetch_cyc = 8'h00, extra = 8'h00;
	int bad_count = 0, num_checks = 0, cycles = 0;
	int ows[6] = '{16, 13, 12, 9, 8, 4};
	ifd_note_s notes[$];
	logic [1:0] lens[$];

	initial begin
		forever #2 clock = ~clock;
	end

	ifd_fetch_model fetch (.clock_i(clock), .word_valid_o(word_valid),
		.word_o(word), .addr_lsb_o(addr_lsb), .fmt_o(fmt), .ctrl_o(ctrl),
		.first_o(first_word), .cond_true_o(cond_true),
		.wait_irq_o(wait_irq));

	ifd_decoder dut (.clock_i(clock), .rst_n_i(rst_n),
		.word_valid_i(word_valid), .word_i(word), .addr_lsb_i(addr_lsb),
		.fmt_i(fmt), .ctrl_i(ctrl), .word_ready_o(word_ready), .len_o(len),
		.cond_true_i(cond_true), .wait_irq_i(wait_irq),
		.dec_valid_o(dec_valid), .bad_addr_o(bad_addr), .opcode_o(opcode),
		.opcode_width_o(owidth), .operands_o(operands), .imm_o(imm),
		.words_o(words), .op1_reg_o(op1_reg), .op1_low_half_o(op1_low),
		.ex_cycles_o(ex_cycles), .flush_o(flush), .exc_i(exc),
		.wide_dispatch_select_i(wide),
		.alt_stack_error_handling_i(alt[0]), .alt_trace_handling_i(alt[1]),
		.alt_debug_handling_i(alt[2]),
		.alt_breakpoint_handling_i(alt[3]), .inflight_cycles_i(inflight),
		.fetch_cycles_i(fetch_cyc), .extra_cycles_i(extra),
		.entry_cycles_o(entry), .latency_o(latency));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Builds one instruction, notes what the decoder must report, sends it
	task automatic run(input int fi, input int ci, input logic lsb,
		input int gap);
		logic [15:0] w [3];
		ifd_note_s e;
		logic cnd, wirq;
		int n;
		int ow;
		w[0] = 16'($urandom);
		w[1] = 16'($urandom);
		w[2] = 16'($urandom);
		cnd = 1'($urandom);
		wirq = 1'($urandom);
		e = '{default: 0};
		n = (fi < 6) ? 1 : (fi < 10) ? 2 : 3;
		e.bad = lsb;
		e.words = 2'(n);
		// Plain two-word layouts carry an 8-bit opcode, the wide one 12
		if (fi < 9 || fi == 12) begin
			e.k_opc = 1'b1;
			ow = (fi < 6) ? ows[fi] : (fi == 12) ? 12 : 8;
			e.ow = 5'(ow);
			e.opc = 20'(w[0] >> (16 - ow));
			e.opr = w[0] & 16'((17'h1 << (16 - ow)) - 1);
			e.k_r1 = (fi > 1);
			e.r1 = w[0][3:0];
		end
		if (fi > 8 && fi < 12) begin
			e.k_opc = 1'b1;
			e.ow = 5'h14;
			e.opc = {w[0], w[1][15:12]};
			e.opr = {4'h0, w[1][11:0]};
		end
		e.k_imm = 1'b1;
		case (fi)
			6: e.imm = {12'h000, w[0][3:0], w[1]};
			7: e.imm = {16'h0000, w[1]};
			8: e.imm = {8'h00, w[0][7:0], w[1]};
			10: e.imm = {12'h000, w[1][11:8], w[2]};
			11: e.imm = {8'h00, w[1][3:0], w[1][11:8], w[2]};
			12: e.imm = {w[2], w[1]};
			default: e.k_imm = 1'b0;
		endcase
		e.cyc = (ci == 1 || ci == 5) ? 8'h02 : (ci == 6) ? 8'h05 : 8'h01;
		e.fl = (ci == 1 || ci == 3 || ci == 6) ||
			((ci == 4 || ci == 5) && cnd) || (ci == 7 && wirq);
		notes.push_back(e);
		lens.push_back(2'(n));
		fetch.send(w, n, ifd_fmt_e'(fi), ifd_ctrl_e'(ci), lsb, cnd, wirq,
			gap);
	endtask

	always @(negedge clock) begin
		ifd_note_s e;
		logic [1:0] l;
		#1;
		if (word_valid === 1'b1 && first_word === 1'b1) begin
			l = lens.pop_front();
			if (!addr_lsb) `CHK(len, l, "length on first word")
		end
		if (dec_valid === 1'b1 || bad_addr === 1'b1) begin
			e = notes.pop_front();
			`CHK(bad_addr, e.bad, "odd address flag")
			if (e.bad) `CHK(dec_valid, 1'b0, "decode on odd address")
			if (!e.bad) begin
				`CHK(words, e.words, "word count")
				`CHK(ex_cycles, e.cyc, "execute cycles")
				`CHK(flush, e.fl, "flush")
			end
			if (!e.bad && e.k_opc) begin
				`CHK(opcode, e.opc, "opcode")
				`CHK(owidth, e.ow, "opcode width")
				`CHK(operands, e.opr, "operands")
			end
			if (!e.bad && e.k_imm) `CHK(imm, e.imm, "immediate")
			if (!e.bad && e.k_r1) begin
				`CHK(op1_reg, e.r1, "register code")
				`CHK(op1_low, e.r1 >= 4'hc, "low half")
			end
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(6));
		repeat (8) @(posedge clock);
		`CHK(word_ready, 1'b1, "ready in reset")
		`CHK(len, LEN_ZERO, "idle length")
		`CHK(dec_valid, 1'b0, "valid in reset")
		@(negedge clock);
		rst_n = 1'b1;
		for (int i = 0; i < 52; i++) begin
			run(i % 13, i % 9, (i % 13 < 6 && i % 5 == 0), $urandom % 2);
		end
		@(negedge clock);
		fetch.idle();
		repeat (4) @(negedge clock);
		`CHK(notes.size(), 0, "missing decode results")
		for (int i = 0; i < 28; i++) begin
			exc = ifd_exc_e'(i % 7);
			wide = 1'($urandom);
			alt = 4'($urandom);
			inflight = 8'($urandom);
			fetch_cyc = 8'($urandom);
			extra = 8'($urandom);
			@(negedge clock);
			ent = ((i % 7 == 0) ? 8'h0c : (i % 7 < 3) ? 8'h0b : 8'h09) +
				8'(wide);
			if (i % 7 inside {[2:5]} && alt[i % 7 - 2]) ent = 8'h0c;
			`CHK(entry, ent, "entry cycles")
			`CHK(latency, 8'(inflight + ent + fetch_cyc + extra), "lat")
		end
		finish_test();
	end
endmodule
